// ==== verilog/safety_gate_monitor.sv ====
`timescale 1ns/100ps
// What this block does
// - Channels on inputs one, two; lock third
// - Two-channel: both active within skew limit
// - Limit off or 0.5-3.0 s, default 3.0
// - Skew limit used only in two-channel modes
// - Release closes only when all conditions hold
// - Fault contact closes on detected error
// - Running skew timer value is output
// - Diagnostic word shows current state
// - Optional activation input gates the block
// - Restart manual, controlled or automatic; default manual
// - Acknowledge restarts in manual and controlled
// - Proof test after reset and reactivation
// - Acknowledge needed after proof test before release, except in automatic restart
// - Proof test optional, default not required
// - Proof test unavailable in locked modes
// - Four evaluation modes, default two-channel
// - Locked modes also need lock active
// - Any monitored input drop opens release
// - Skew error clears when both channels drop
// - Distinct diagnostic codes per state
module safety_gate_monitor
    import safety_gate_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Monitored inputs
    input wire logic gate_switch_a_i,
    input wire logic gate_switch_b_i,
    input wire logic lock_monitor_coil_i,
    input wire logic operator_ack_coil_i,
    input wire logic block_activate_coil_i,
    // Configuration
    input wire logic activate_required_i,
    input wire logic [1:0] restart_mode_i,
    input wire logic proof_test_required_i,
    input wire logic [1:0] eval_mode_i,
    input wire logic [2:0] channel_skew_limit_i,
    // Results
    output logic hazard_release_contact_o,
    output logic fault_contact_o,
    output logic [15:0] skew_timer_value_o,
    output logic [15:0] diag_word_o
);

    gate_state_t state_q;
    gate_state_t state_d;
    logic ack_q;
    logic ack_d;
    logic opened_q;
    logic opened_d;
    logic [15:0] diag_q;
    logic [15:0] diag_d;
    logic release_q;
    logic release_d;
    logic fault_q;
    logic fault_d;
    logic timer_run;
    logic timer_expired;
    logic [15:0] timer_ms;

    restart_mode_t mode;
    eval_mode_t eval;
    logic dual;
    logic locked;
    logic proof_on;
    logic active;
    logic any_in;
    logic gates_ok;
    logic all_ok;
    logic split;
    logic ack_event;
    logic [2:0] limit_sel;

    function automatic logic is_dual(input eval_mode_t e);
        is_dual = (e == dual_channel_eval) || (e == dual_channel_locked);
    endfunction

    function automatic logic is_locked(input eval_mode_t e);
        is_locked = (e == single_channel_locked) ||
            (e == dual_channel_locked);
    endfunction

    // Channels disagree; single-channel modes never split
    function automatic logic chans_split(input logic two_ch,
        input logic ch_a, input logic ch_b);
        chans_split = two_ch && (ch_a != ch_b);
    endfunction

    // Unused code falls back to the safest restart
    function automatic restart_mode_t decode_mode(input logic [1:0] m);
        if (m == 2'b11)
            decode_mode = manual_restart_mode;
        else
            decode_mode = restart_mode_t'(m);
    endfunction

    function automatic logic [2:0] clamp_limit(input logic [2:0] sel);
        clamp_limit = (sel > SKEW_SEL_MAX) ? SKEW_SEL_MAX : sel;
    endfunction

    // Manual acts on the press, controlled on the release
    function automatic logic ack_edge(input restart_mode_t m,
        input logic now_lvl, input logic prev_lvl);
        if (m == controlled_restart_mode)
            ack_edge = !now_lvl && prev_lvl;
        else
            ack_edge = now_lvl && !prev_lvl;
    endfunction

    always_comb
    begin
        mode = decode_mode(restart_mode_i);
        eval = eval_mode_t'(eval_mode_i);
        dual = is_dual(eval);
        locked = is_locked(eval);
        proof_on = proof_test_required_i && !locked;
        active = !activate_required_i || block_activate_coil_i;
        // Single-channel modes only look at channel a
        any_in = gate_switch_a_i || (dual && gate_switch_b_i);
        gates_ok = gate_switch_a_i && (!dual || gate_switch_b_i);
        all_ok = gates_ok && (!locked || lock_monitor_coil_i);
        split = chans_split(dual, gate_switch_a_i, gate_switch_b_i);
        ack_event = ack_edge(mode, operator_ack_coil_i, ack_q);
        limit_sel = clamp_limit(channel_skew_limit_i);
    end

    // Acknowledge history for edge detection
    always_comb
    begin
        ack_d = operator_ack_coil_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            ack_q <= 1'b0;
        else
            ack_q <= ack_d;
    end

    // Split that began with an opening, not with a late closing
    always_comb
    begin
        opened_d = opened_q;
        if (!active || !split)
            opened_d = 1'b0;
        else if (state_q == st_wait_ack || state_q == st_released)
            opened_d = 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            opened_q <= 1'b0;
        else
            opened_q <= opened_d;
    end

    // Skew timer runs from first channel until second, two-channel only
    always_comb
    begin
        timer_run = active && split &&
            (state_q == st_wait_in);
    end

    skew_timer u_skew_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .run_i(timer_run),
        .limit_sel_i(limit_sel),
        .expired_o(timer_expired),
        .value_ms_o(timer_ms)
    );

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            st_idle:
            begin
                if (active)
                    state_d = proof_on ? st_proof : st_wait_in;
            end
            st_proof:
            begin
                // Gate has to be seen open before release
                if (!any_in)
                    state_d = st_wait_in;
            end
            st_wait_in:
            begin
                if (timer_expired)
                    state_d = st_error;
                else if (all_ok)
                begin
                    if (mode == automatic_restart_mode)
                        state_d = st_released;
                    else
                        state_d = st_wait_ack;
                end
            end
            st_wait_ack:
            begin
                if (!all_ok)
                    state_d = st_wait_in;
                else if (ack_event)
                    state_d = st_released;
            end
            st_released:
            begin
                if (!all_ok)
                    state_d = st_wait_in;
            end
            st_error:
            begin
                if (!gate_switch_a_i && !gate_switch_b_i)
                    state_d = st_wait_in;
            end
            default:
                state_d = st_idle;
        endcase
        if (!active)
            state_d = st_idle;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            state_q <= st_idle;
        else
            state_q <= state_d;
    end

    // Safety contacts kept apart from the diagnostic path
    always_comb
    begin
        // Drop of any monitored input opens release at once
        release_d = (state_d == st_released) && all_ok &&
            active;
        fault_d = (state_d == st_error);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            release_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            release_q <= release_d;
            fault_q <= fault_d;
        end
    end

    // Diagnostic code for standard logic
    always_comb
    begin
        case (state_d)
            st_idle:
                diag_d = DIAG_NO_ENABLE;
            st_proof:
                diag_d = DIAG_WAIT_PROOF;
            st_wait_in:
            begin
                if (split && opened_d)
                    diag_d = DIAG_ONE_OPENED;
                else if (split)
                    diag_d = DIAG_WAIT_SECOND;
                else if (gates_ok && !all_ok)
                    diag_d = DIAG_WAIT_LOCK;
                else
                    diag_d = DIAG_WAIT_FIRST;
            end
            st_wait_ack:
                diag_d = (mode == manual_restart_mode) ?
                    DIAG_WAIT_ACK_RISE : DIAG_WAIT_ACK_FALL;
            st_released:
                diag_d = DIAG_RELEASED;
            st_error:
                diag_d = DIAG_ERR_SKEW;
            default:
                diag_d = DIAG_NO_ENABLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            diag_q <= DIAG_NO_ENABLE;
        else
            diag_q <= diag_d;
    end

    assign hazard_release_contact_o = release_q;
    assign fault_contact_o = fault_q;
    assign skew_timer_value_o = timer_ms;
    assign diag_word_o = diag_q;

endmodule

// ==== inc/safety_gate_pkg.sv ====
package safety_gate_pkg;

    // Skew limit encoding: 0 = off, n = n * 0.5 s (n = 1..6)
    localparam int SKEW_SEL_W = 3;
    localparam logic [2:0] SKEW_SEL_OFF = 3'h0;
    localparam logic [2:0] SKEW_SEL_MAX = 3'h6;
    localparam logic [2:0] SKEW_SEL_DEFAULT = 3'h6;

    localparam int CLK_FREQ_HZ = 125000000;
    localparam int SKEW_STEP_MS = 500;
    // Cycles in one 0.5 s step
    localparam int SKEW_STEP_CYCLES = CLK_FREQ_HZ / 1000 * SKEW_STEP_MS;
    localparam int SKEW_TIMER_W = 32;
    // Timer value published in milliseconds
    localparam int MS_CYCLES = CLK_FREQ_HZ / 1000;
    localparam int MS_CNT_W = 17;
    localparam int SKEW_MS_W = 16;

    localparam int DIAG_W = 16;
    localparam logic [15:0] DIAG_NO_ENABLE = 16'h0000;
    localparam logic [15:0] DIAG_WAIT_FIRST = 16'h2001;
    localparam logic [15:0] DIAG_WAIT_SECOND = 16'h2002;
    localparam logic [15:0] DIAG_WAIT_ACK_RISE = 16'h2003;
    localparam logic [15:0] DIAG_WAIT_ACK_FALL = 16'h2004;
    localparam logic [15:0] DIAG_ONE_OPENED = 16'h2005;
    localparam logic [15:0] DIAG_WAIT_PROOF = 16'h200e;
    localparam logic [15:0] DIAG_WAIT_LOCK = 16'h2015;
    localparam logic [15:0] DIAG_RELEASED = 16'h8009;
    localparam logic [15:0] DIAG_ERR_SKEW = 16'hf001;

    typedef enum logic [1:0] {
        manual_restart_mode = 2'b00,
        controlled_restart_mode = 2'b01,
        automatic_restart_mode = 2'b10
    } restart_mode_t;
    localparam logic [1:0] RESTART_DEFAULT = 2'b00;

    typedef enum logic [1:0] {
        single_channel_eval = 2'b00,
        dual_channel_eval = 2'b01,
        single_channel_locked = 2'b10,
        dual_channel_locked = 2'b11
    } eval_mode_t;
    localparam logic [1:0] EVAL_DEFAULT = 2'b01;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_proof = 3'b001,
        st_wait_in = 3'b010,
        st_wait_ack = 3'b011,
        st_released = 3'b100,
        st_error = 3'b101
    } gate_state_t;

endpackage

// ==== verilog/skew_timer.sv ====
`timescale 1ns/100ps
// Discrepancy timer: counts while running, flags expiry of the limit
module skew_timer
    import safety_gate_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] limit_sel_i,
    // Status
    output logic expired_o,
    output logic [15:0] value_ms_o
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [16:0] ms_div_q;
    logic [16:0] ms_div_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic expired_q;
    logic expired_d;

    function automatic logic [31:0] limit_cycles(input logic [2:0] sel);
        limit_cycles = 32'(sel) * 32'(SKEW_STEP_CYCLES);
    endfunction

    always_comb
    begin
        cnt_d = cnt_q;
        ms_div_d = ms_div_q;
        ms_d = ms_q;
        expired_d = expired_q;
        if (!run_i)
        begin
            cnt_d = '0;
            ms_div_d = '0;
            ms_d = '0;
            expired_d = 1'b0;
        end
        else
        begin
            if (cnt_q != 32'hffffffff)
                cnt_d = cnt_q + 32'h1;
            if (ms_div_q == 17'(MS_CYCLES - 1))
            begin
                ms_div_d = '0;
                if (ms_q != 16'hffff)
                    ms_d = ms_q + 16'h1;
            end
            else
                ms_div_d = ms_div_q + 17'h1;
            // Off never expires
            if (limit_sel_i != SKEW_SEL_OFF &&
                cnt_q >= limit_cycles(limit_sel_i))
                expired_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q <= '0;
            ms_div_q <= '0;
            ms_q <= '0;
            expired_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            ms_div_q <= ms_div_d;
            ms_q <= ms_d;
            expired_q <= expired_d;
        end
    end

    assign expired_o = expired_q;
    assign value_ms_o = ms_q;

endmodule

// ==== sim/safety_gate_props.sv ====
`timescale 1ns/100ps
module safety_gate_props
    import safety_gate_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic gate_switch_a_i,
    input wire logic gate_switch_b_i,
    input wire logic lock_monitor_coil_i,
    input wire logic operator_ack_coil_i,
    input wire logic [1:0] restart_mode_i,
    input wire logic [1:0] eval_mode_i,
    // Outputs
    input wire logic hazard_release_contact_o,
    input wire logic fault_contact_o,
    input wire logic [15:0] skew_timer_value_o,
    input wire logic [15:0] diag_word_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence chans_equal;
        (gate_switch_a_i == gate_switch_b_i) [*3];
    endsequence

    chan_a_drop_a: assert property (
        !gate_switch_a_i |=> !hazard_release_contact_o)
        else $error("release held after channel one opened");
    chan_b_drop_a: assert property (
        eval_mode_i[0] && !gate_switch_b_i |=> !hazard_release_contact_o)
        else $error("release held after channel two opened");
    lock_drop_a: assert property (
        eval_mode_i[1] && !lock_monitor_coil_i
        |=> !hazard_release_contact_o)
        else $error("release held without guard lock");
    release_code_a: assert property (
        hazard_release_contact_o == (diag_word_o == DIAG_RELEASED))
        else $error("release and diagnostic code disagree");
    fault_code_a: assert property (
        fault_contact_o == (diag_word_o == DIAG_ERR_SKEW))
        else $error("fault and diagnostic code disagree");
    manual_ack_a: assert property (
        $rose(hazard_release_contact_o) && restart_mode_i == 2'b00
        |-> $past(operator_ack_coil_i) && !$past(operator_ack_coil_i, 2))
        else $error("manual release without acknowledge");
    ctrl_ack_a: assert property (
        $rose(hazard_release_contact_o) && restart_mode_i == 2'b01
        |-> !$past(operator_ack_coil_i) && $past(operator_ack_coil_i, 2))
        else $error("controlled release without falling acknowledge");
    timer_idle_a: assert property (
        chans_equal |-> skew_timer_value_o == 16'h0000)
        else $error("skew timer runs with equal channels");
endmodule

bind safety_gate_monitor safety_gate_props i_props (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .gate_switch_a_i(gate_switch_a_i),
    .gate_switch_b_i(gate_switch_b_i),
    .lock_monitor_coil_i(lock_monitor_coil_i),
    .operator_ack_coil_i(operator_ack_coil_i),
    .restart_mode_i(restart_mode_i),
    .eval_mode_i(eval_mode_i),
    .hazard_release_contact_o(hazard_release_contact_o),
    .fault_contact_o(fault_contact_o),
    .skew_timer_value_o(skew_timer_value_o),
    .diag_word_o(diag_word_o)
);

// ==== sim/gate_partner.sv ====
`timescale 1ns/100ps
module gate_partner (
    // Clock
    input wire logic clk_sys_i,
    // Switches and button
    output logic gate_switch_a_o,
    output logic gate_switch_b_o,
    output logic lock_monitor_coil_o,
    output logic operator_ack_coil_o
);
    logic [3:0] lines_q = 4'h0;

    assign {operator_ack_coil_o, lock_monitor_coil_o} = lines_q[3:2];
    assign {gate_switch_b_o, gate_switch_a_o} = lines_q[1:0];

    // Levels change only after a falling edge
    task automatic drive(input logic [3:0] v);
        @(negedge clk_sys_i);
        lines_q = v;
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import safety_gate_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic en = 1'b0;
    logic en_req = 1'b0;
    logic [1:0] rs = 2'b00;
    logic pf = 1'b0;
    logic [1:0] ev = 2'b01;
    logic [2:0] lim = SKEW_SEL_DEFAULT;
    logic sw_a, sw_b, lock, ack, rel, flt;
    logic [15:0] timer_v, diag;
    int mismatches = 0;
    int tests_run = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    gate_partner i_partner (.clk_sys_i(clk_sys_i), .gate_switch_a_o(sw_a),
        .gate_switch_b_o(sw_b), .lock_monitor_coil_o(lock),
        .operator_ack_coil_o(ack));

    safety_gate_monitor i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .gate_switch_a_i(sw_a), .gate_switch_b_i(sw_b),
        .lock_monitor_coil_i(lock), .operator_ack_coil_i(ack),
        .block_activate_coil_i(en), .activate_required_i(en_req),
        .restart_mode_i(rs), .proof_test_required_i(pf),
        .eval_mode_i(ev), .channel_skew_limit_i(lim),
        .hazard_release_contact_o(rel), .fault_contact_o(flt),
        .skew_timer_value_o(timer_v), .diag_word_o(diag));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic restart(input logic [1:0] m, input logic [1:0] e,
        input logic p, input logic r, input logic [3:0] v);
        if (tests_run > 0)
            $display("Test done, mismatches %0d", mismatches);
        i_partner.drive(v);
        reset_n_i = 1'b0;
        {rs, ev, pf, en_req} = {m, e, p, r};
        repeat (2) @(negedge clk_sys_i);
        check(diag, DIAG_NO_ENABLE);
        reset_n_i = 1'b1;
    endtask

    task automatic step(input logic [3:0] v, input logic r,
        input logic [15:0] d);
        i_partner.drive(v);
        repeat (3) @(negedge clk_sys_i);
        check({15'h0, rel}, {15'h0, r});
        check({15'h0, flt}, 16'h0000);
        check(diag, d);
        check(timer_v, 16'h0000);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        restart(2'b00, 2'b01, 1'b0, 1'b0, 4'h0);
        step(4'h1, 1'b0, DIAG_WAIT_SECOND);
        step(4'h3, 1'b0, DIAG_WAIT_ACK_RISE);
        step(4'hb, 1'b1, DIAG_RELEASED);
        step(4'h3, 1'b1, DIAG_RELEASED);
        step(4'h0, 1'b0, DIAG_WAIT_FIRST);
        restart(2'b01, 2'b01, 1'b0, 1'b0, 4'h0);
        step(4'h3, 1'b0, DIAG_WAIT_ACK_FALL);
        step(4'hb, 1'b0, DIAG_WAIT_ACK_FALL);
        step(4'h3, 1'b1, DIAG_RELEASED);
        step(4'h1, 1'b0, DIAG_ONE_OPENED);
        step(4'h3, 1'b0, DIAG_WAIT_ACK_FALL);
        restart(2'b10, 2'b01, 1'b0, 1'b0, 4'h0);
        step(4'h3, 1'b1, DIAG_RELEASED);
        lim = SKEW_SEL_OFF;
        restart(2'b00, 2'b00, 1'b0, 1'b0, 4'h0);
        step(4'h1, 1'b0, DIAG_WAIT_ACK_RISE);
        step(4'h9, 1'b1, DIAG_RELEASED);
        restart(2'b10, 2'b11, 1'b1, 1'b0, 4'h3);
        step(4'h3, 1'b0, DIAG_WAIT_LOCK);
        step(4'h7, 1'b1, DIAG_RELEASED);
        step(4'h3, 1'b0, DIAG_WAIT_LOCK);
        restart(2'b00, 2'b01, 1'b1, 1'b1, 4'h3);
        step(4'h3, 1'b0, DIAG_NO_ENABLE);
        en = 1'b1;
        step(4'h3, 1'b0, DIAG_WAIT_PROOF);
        step(4'h0, 1'b0, DIAG_WAIT_FIRST);
        step(4'h3, 1'b0, DIAG_WAIT_ACK_RISE);
        step(4'hb, 1'b1, DIAG_RELEASED);
        en = 1'b0;
        step(4'h3, 1'b0, DIAG_NO_ENABLE);
        en = 1'b1;
        step(4'h3, 1'b0, DIAG_WAIT_PROOF);
        $display("Test done, mismatches %0d", mismatches);
        wrap_up();
    end
endmodule
